// ==== logic/ext_mem_port.sv ====
// External asynchronous memory port: address, selects, strobes, data mux
// ==========================================
`timescale 1ns/100ps
module ext_mem_port
   import ext_port_pkg::*;
#(
   parameter int STROBE_CYCLES = ext_port_pkg::STROBE_CYC
) (
   // Clock and reset
   input  wire logic                            CLK_SYS,
   input  wire logic                            RST,
   // Core request
   input  wire logic                            REQ_VALID,
   input  wire logic                            REQ_WRITE,
   input  wire logic                            REQ_COND_TRUE,
   input  wire logic [ext_port_pkg::ADDR_W-1:0] REQ_ADDR,
   input  wire logic [ext_port_pkg::DATA_W-1:0] REQ_WDATA,
   output logic                                 REQ_READY,
   output logic                                 RSP_VALID,
   output logic [ext_port_pkg::DATA_W-1:0]      RSP_RDATA,
   // Configuration
   input  wire ext_port_pkg::data_use_t         DATA_USE,
   input  wire logic                            ACQ_ENABLE,
   input  wire ext_port_pkg::flag_use_t         FLAG2_USE,
   input  wire ext_port_pkg::flag_use_t         FLAG3_USE,
   input  wire logic                            EXTERNAL_PORT_BOOT,
   // Memory pins
   output logic [ext_port_pkg::ADDR_W-1:0]      ADDR,
   output logic [1:0]                           BANK_SELECT_N,
   output logic                                 RD_N,
   output logic                                 WR_N,
   input  wire logic                            ACK,
   input  wire logic [ext_port_pkg::DATA_W-1:0] DATA_I,
   output logic [ext_port_pkg::DATA_W-1:0]      DATA_O,
   output logic                                 DATA_OE,
   // Acquisition channel zero
   output logic                                 ACQ_VALID,
   output logic [ext_port_pkg::DATA_W-1:0]      ACQ_DATA,
   // Flag pins 0-3
   input  wire logic [3:0]                      FLAG_I,
   input  wire logic [3:0]                      FLAG_DO,
   input  wire logic [3:0]                      FLAG_DIR_OUT,
   input  wire logic                            TIMER_EXPIRY_IN,
   output logic [3:0]                           FLAG_O,
   output logic [3:0]                           FLAG_OE,
   output logic [3:0]                           FLAG_PULLUP,
   output logic [3:0]                           FLAG_IN_Q,
   output logic                                 IRQ2_REQ
);
   import ext_port_pkg::*;

   // Strobe counter is eight bits wide
   if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin : g_bad_strobe
      $error("ext_mem_port: STROBE_CYCLES must be 1..255");
   end

   // ==========================================
   // State
   acc_state_t              state_q, state_d;
   logic [7:0]              cnt_q, cnt_d;
   logic [ADDR_W-1:0]       addr_q;
   logic [DATA_W-1:0]       wdata_q;
   logic                    write_q;
   logic [3:0]              sel_q;
   logic [3:0]              sel_d;

   // ==========================================
   // Decode
   wire external_memory_mode = (DATA_USE == PIN_EXTERNAL_MEMORY_MODE);
   // Taken only on the advertised ready, never on the edge after reset
   wire take      = REQ_VALID && REQ_READY && (state_q == ST_IDLE) &&
                    external_memory_mode;
   wire in_access = (state_q != ST_IDLE);
   // Selects follow the strobe, so none is left low once ready returns
   wire sel_active = (state_d == ST_STROBE);
   wire strobe    = (state_q == ST_STROBE);
   wire [1:0] bank_now = addr_q[BANK_LSB +: BANK_W];
   // Banks 2/3 only exist when the flag pin is given to bank select
   wire [3:0] bank_en = {FLAG3_USE == FLG_BANK, FLAG2_USE == FLG_BANK,
                         2'b11};
   wire wait_done = (cnt_q >= STROBE_CYCLES[7:0]);
   // Selects decoded from the held address, so they move with ADDR
   // Condition outcome is deliberately ignored here
   bank_decode #(.NB(NBANKS)) u_dec (
      .bank    (bank_now),
      .active  (sel_active),
      .bank_en (bank_en),
      .sel_n   (sel_d)
   );

   // ==========================================
   // Sequencer
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_IDLE: begin
            cnt_d = 8'h00;
            if (take) state_d = ST_SETUP;
         end
         ST_SETUP: begin
            state_d = ST_STROBE;
            cnt_d   = 8'h01;
         end
         ST_STROBE: begin
            if (!wait_done) cnt_d = cnt_q + 8'h01;
            // Never finish while the acknowledge is held low
            if (wait_done && ACK) state_d = ST_DONE;
         end
         ST_DONE:  state_d = ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_q <= ST_IDLE;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Request latched once, held for the whole access
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         addr_q  <= ADDR_RST;
         wdata_q <= 32'h00000000;
         write_q <= 1'b0;
      end else if (take) begin
         addr_q  <= REQ_ADDR;
         wdata_q <= REQ_WDATA;
         write_q <= REQ_WRITE;
      end
   end

   // ==========================================
   // Pin registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ADDR          <= ADDR_RST;
         BANK_SELECT_N <= 2'b11;
         sel_q         <= SEL_RST;
         RD_N          <= 1'b1;
         WR_N          <= 1'b1;
         DATA_O        <= 32'h00000000;
         DATA_OE       <= 1'b0;
         REQ_READY     <= 1'b0;
         RSP_VALID     <= 1'b0;
         RSP_RDATA     <= 32'h00000000;
      end else begin
         ADDR          <= addr_q;
         sel_q         <= sel_d;
         // Select 1 also reaches the boot flash in external boot mode
         BANK_SELECT_N <= sel_d[1:0];
         RD_N          <= ~(state_d == ST_STROBE && !write_q);
         WR_N          <= ~(state_d == ST_STROBE && write_q);
         DATA_O        <= wdata_q;
         DATA_OE       <= in_access && write_q && external_memory_mode;
         REQ_READY     <= (state_d == ST_IDLE) && external_memory_mode;
         RSP_VALID     <= (state_q == ST_STROBE) && (state_d == ST_DONE);
         if (strobe && !write_q && state_d == ST_DONE)
            RSP_RDATA  <= DATA_I;
      end
   end

   // ==========================================
   // Acquisition channel zero
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ACQ_VALID <= 1'b0;
         ACQ_DATA  <= 32'h00000000;
      end else begin
         ACQ_VALID <= (DATA_USE == PIN_PARALLEL_ACQUISITION_PORT) &&
                      ACQ_ENABLE;
         ACQ_DATA  <= DATA_I;
      end
   end

   // ==========================================
   // Flag pins; reset leaves all four as plain flag inputs
   wire [3:0] fl_o = {
      (FLAG3_USE == FLG_BANK) ? sel_d[3] :
      (FLAG3_USE == FLG_ALT)  ? TIMER_EXPIRY_IN : FLAG_DO[3],
      (FLAG2_USE == FLG_BANK) ? sel_d[2] : FLAG_DO[2],
      FLAG_DO[1:0]};
   wire [3:0] fl_oe = {
      (FLAG3_USE == FLG_BANK) || (FLAG3_USE == FLG_ALT) ||
         (FLAG3_USE == FLG_FLAG && FLAG_DIR_OUT[3]),
      (FLAG2_USE == FLG_BANK) ||
         (FLAG2_USE == FLG_FLAG && FLAG_DIR_OUT[2]),
      FLAG_DIR_OUT[1:0]};

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         FLAG_O      <= 4'h0;
         FLAG_OE     <= 4'h0;
         FLAG_PULLUP <= 4'h0;
         FLAG_IN_Q   <= 4'h0;
         IRQ2_REQ    <= 1'b0;
      end else begin
         FLAG_O      <= fl_o;
         FLAG_OE     <= fl_oe;
         FLAG_PULLUP <= {FLAG3_USE == FLG_BANK, FLAG2_USE == FLG_BANK,
                         2'b00};
         FLAG_IN_Q   <= FLAG_I;
         IRQ2_REQ    <= (FLAG2_USE == FLG_ALT) && !FLAG_I[2];
      end
   end

   // Condition flag and boot strap are informational only
   wire unused_ok = REQ_COND_TRUE ^ EXTERNAL_PORT_BOOT ^ (|sel_q);
endmodule : ext_mem_port

// ==== common/ext_port_pkg.sv ====
// Package: constants and types of the external asynchronous memory port
package ext_port_pkg;
   // ==========================================
   // Widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int BANK_W = 2;
   localparam int NBANKS = 4;
   // ==========================================
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
   localparam logic [3:0]        SEL_RST  = 4'hF;
   // ==========================================
   // Bank decode: bank field sits in the top address bits
   localparam int BANK_LSB = 22;
   // ==========================================
   // Data pin use
   typedef enum logic [1:0] {
      PIN_EXTERNAL_MEMORY_MODE      = 2'b00,
      PIN_PARALLEL_ACQUISITION_PORT = 2'b01,
      PIN_FLAG  = 2'b10,
      PIN_PWM   = 2'b11
   } data_use_t;
   // Flag pin 2/3 use
   typedef enum logic [1:0] {
      FLG_FLAG  = 2'b00,
      FLG_ALT   = 2'b01,
      FLG_BANK  = 2'b10
   } flag_use_t;
   // ==========================================
   // Access sequencer states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SETUP  = 2'b01,
      ST_STROBE = 2'b10,
      ST_DONE   = 2'b11
   } acc_state_t;
   // ==========================================
   // Timing: least strobe width in ns, cycles derived at 100 ns period
   localparam int CLK_PERIOD_NS = 100;
   localparam int STROBE_MIN_NS = 200;
   localparam int STROBE_CYC    =
      (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : ext_port_pkg

// ==== logic/bank_decode.sv ====
// Bank select decoder, one active-low select per bank
`timescale 1ns/100ps
module bank_decode #(
   parameter int NB = 4
) (
   // Decode inputs
   input  wire logic [1:0]    bank,
   input  wire logic          active,
   input  wire logic [NB-1:0] bank_en,
   // Selects
   output logic [NB-1:0]      sel_n
);
   if (NB < 1 || NB > 4) begin : g_bad_nb
      $error("bank_decode: NB must be 1..4");
   end
   genvar i;
   generate
      for (i = 0; i < NB; i++) begin : g_sel
         assign sel_n[i] = ~(active && bank_en[i] && (bank == 2'(i)));
      end
   endgenerate
endmodule : bank_decode

// ==== verif/ext_mem_port_monitor.sv ====
// Checker of external memory port pin timing
`timescale 1ns/100ps
module ext_mem_port_monitor
   import ext_port_pkg::*;
(
   // Pins
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        REQ_VALID,
   input wire logic        REQ_READY,
   input wire logic [23:0] REQ_ADDR,
   input wire logic        RSP_VALID,
   input wire logic [23:0] ADDR,
   input wire logic [1:0]  BANK_SELECT_N,
   input wire logic        RD_N,
   input wire logic        WR_N,
   input wire logic        ACK,
   input wire logic [31:0] DATA_O,
   input wire logic        DATA_OE
);
   // ==========
   // Assertions
   wire strb = !(RD_N && WR_N);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   a_addr_taken: assert property (REQ_VALID && REQ_READY |=> ##1
      ADDR == $past(REQ_ADDR, 2)) else $error("address not taken");
   a_idle_deselect: assert property (REQ_READY |->
      BANK_SELECT_N == 2'h3) else $error("select low while idle");
   a_end_deselect: assert property (RSP_VALID |=>
      BANK_SELECT_N == 2'h3) else $error("select low after access");
   a_addr_hold: assert property (strb |-> !$past(strb) ||
      ($stable(ADDR) && $stable(BANK_SELECT_N)))
      else $error("address moved in strobe");
   a_wdata_hold: assert property (!WR_N |-> DATA_OE &&
      ($past(WR_N) || $stable(DATA_O)))
      else $error("write data moved in strobe");
   a_sel_in_access: assert property (BANK_SELECT_N != 2'h3 |->
      strb) else $error("select low outside strobe");
   a_bank_decode: assert property (strb |-> BANK_SELECT_N ==
      (ADDR[23] ? 2'h3 : ADDR[22] ? 2'h1 : 2'h2))
      else $error("wrong bank select");
   a_ack_stretch: assert property (strb && !ACK |=>
      strb && !RSP_VALID) else $error("access ended while waiting");
   a_rd_done: assert property ($rose(RD_N) && !$past(RST) |->
      RSP_VALID) else $error("read ended without response");
   a_wr_done: assert property ($rose(WR_N) && !$past(RST) |->
      RSP_VALID) else $error("write ended without response");
endmodule : ext_mem_port_monitor
bind ext_mem_port ext_mem_port_monitor u_mon (.CLK_SYS, .RST,
   .REQ_VALID, .REQ_READY, .REQ_ADDR, .RSP_VALID, .ADDR,
   .BANK_SELECT_N, .RD_N, .WR_N, .ACK, .DATA_O, .DATA_OE);

// ==== verif/async_mem_model.sv ====
// Asynchronous memory with programmable wait states
`timescale 1ns/100ps
module async_mem_model (
   // Port pins
   input wire logic        clk,
   input wire logic [23:0] addr,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic [31:0] data_o,
   output logic            ack,
   output logic [31:0]     data_i,
   // Bench control
   input wire logic [3:0]  wait_n,
   input wire logic [31:0] acq_word
);
   // ==========
   // Storage, aliased on the bank bits and the low six address bits
   logic [31:0] mem [256];
   logic [3:0]  cnt_q;
   wire  [7:0]  idx  = {addr[23:22], addr[5:0]};
   wire         busy = !(rd_n && wr_n);
   always_ff @(posedge clk) begin
      cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
      if (!wr_n) begin
         mem[idx] <= data_o;
      end
   end
   // Pull-up holds ack high outside accesses
   assign ack = busy ? (cnt_q >= wait_n) : 1'b1;
   assign data_i = !rd_n ? mem[idx] : acq_word;
endmodule : async_mem_model

// ==== verif/external_async_memory_port_test.sv ====
// Self-checking bench of the external memory port
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin \
n_mismatch++; $display("ERROR %s exp %h got %h", n, e, g); end end
module external_async_memory_port_test;
   import ext_port_pkg::*;
   typedef struct packed {logic w; logic [23:0] a; logic [31:0] d;} note_t;
   logic CLK_SYS = 1'h0, RST = 1'h1, REQ_VALID = 1'h0, REQ_WRITE = 1'h0;
   logic REQ_COND_TRUE = 1'h1, ACQ_ENABLE = 1'h0, EXTERNAL_PORT_BOOT = 1'h0;
   logic TIMER_EXPIRY_IN = 1'h0, REQ_READY, RSP_VALID, RD_N, WR_N, w_seen;
   logic ACK, DATA_OE, ACQ_VALID, IRQ2_REQ;
   logic [23:0] REQ_ADDR = 24'h0, ADDR, a_seen;
   logic [23:0] adr [8];
   logic [31:0] REQ_WDATA = 32'h0, RSP_RDATA, DATA_I, DATA_O, ACQ_DATA;
   logic [31:0] acq_word = 32'hFFFFFFFF;
   logic [31:0] shadow [256];
   logic [1:0]  BANK_SELECT_N, s_seen, f_seen, f_exp;
   logic [3:0]  FLAG_I = 4'hF, FLAG_DO = 4'h0, FLAG_DIR_OUT = 4'h0;
   logic [3:0]  FLAG_O, FLAG_OE, FLAG_PULLUP, FLAG_IN_Q, wait_n = 4'h0;
   data_use_t   DATA_USE = PIN_EXTERNAL_MEMORY_MODE;
   flag_use_t   FLAG2_USE = FLG_FLAG, FLAG3_USE = FLG_FLAG;
   note_t       q[$];
   note_t       e;
   int          n_mismatch = 0, check_count = 0;
   always #50 CLK_SYS = ~CLK_SYS;
   ext_mem_port dut (.CLK_SYS, .RST, .REQ_VALID, .REQ_WRITE,
      .REQ_COND_TRUE, .REQ_ADDR, .REQ_WDATA, .REQ_READY, .RSP_VALID,
      .RSP_RDATA, .DATA_USE, .ACQ_ENABLE, .FLAG2_USE, .FLAG3_USE,
      .EXTERNAL_PORT_BOOT, .ADDR, .BANK_SELECT_N, .RD_N, .WR_N, .ACK,
      .DATA_I, .DATA_O, .DATA_OE, .ACQ_VALID, .ACQ_DATA, .FLAG_I,
      .FLAG_DO, .FLAG_DIR_OUT, .TIMER_EXPIRY_IN, .FLAG_O, .FLAG_OE,
      .FLAG_PULLUP, .FLAG_IN_Q, .IRQ2_REQ);
   async_mem_model mem (.clk(CLK_SYS), .addr(ADDR), .rd_n(RD_N),
      .wr_n(WR_N), .data_o(DATA_O), .ack(ACK), .data_i(DATA_I),
      .wait_n(wait_n), .acq_word(acq_word));
   task automatic close_out();
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   // Takes one request; the result is checked by the watcher below
   task automatic access(input logic w, input logic [23:0] a);
      int i;
      logic [7:0] k;
      k = {a[23:22], a[5:0]};
      for (i = 0; i < 50 && REQ_READY !== 1'b1; i++) @(negedge CLK_SYS);
      if (REQ_READY !== 1'b1) begin
         n_mismatch++;
         close_out();
      end else begin
         REQ_VALID = 1'b1;
         REQ_WRITE = w;
         REQ_ADDR = a;
         REQ_WDATA = $urandom;
         REQ_COND_TRUE = 1'($urandom);
         wait_n = 4'($urandom_range(3));
         if (w) shadow[k] = REQ_WDATA;
         q.push_back({w, a, shadow[k]});
         @(negedge CLK_SYS);
         REQ_VALID = 1'b0;
      end
   endtask : access
   // Watcher samples mid-cycle, away from the launching edge
   always @(negedge CLK_SYS) begin
      if (!RD_N || !WR_N) begin
         a_seen = ADDR;
         s_seen = BANK_SELECT_N;
         w_seen = !WR_N;
         f_seen = FLAG_O[3:2];
      end
      if (RSP_VALID === 1'b1) begin
         if (q.size() == 0) `CHK("queue", 1'b1, 1'b0)
         else begin
            e = q.pop_front();
            `CHK("addr", e.a, a_seen)
            `CHK("kind", e.w, w_seen)
            `CHK("select", (e.a[23] ? 2'h3 : ~(2'h1 << e.a[22])), s_seen)
            if (!e.w) `CHK("rdata", e.d, RSP_RDATA)
            f_exp = e.a[23] ? ~(2'h1 << e.a[22]) : 2'h3;
            if (FLAG2_USE == FLG_BANK && FLAG3_USE == FLG_BANK)
               `CHK("flag_sel", f_exp, f_seen)
         end
      end
   end
   initial begin
      void'($urandom(108));
      repeat (6) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      `CHK("rst_sel", 2'h3, BANK_SELECT_N)
      `CHK("rst_strb", 2'h3, {RD_N, WR_N})
      `CHK("rst_oe", 1'b0, DATA_OE)
      `CHK("rst_flag_oe", 4'h0, FLAG_OE)
      RST = 1'b0;
      for (int i = 0; i < 8; i++) adr[i] = {2'($urandom), 16'($urandom), 6'(i)};
      for (int i = 0; i < 8; i++) access(1'b1, adr[i]);
      for (int i = 0; i < 8; i++) access(1'b0, adr[i]);
      // Let the last read finish before the pins change use
      for (int i = 0; i < 100 && q.size() != 0; i++) @(negedge CLK_SYS);
      `CHK("drain_rd", 1'b1, q.size() == 0)
      for (int u = 0; u < 4; u++) begin
         DATA_USE = data_use_t'(u);
         ACQ_ENABLE = 1'b1;
         acq_word = $urandom;
         repeat (2) @(negedge CLK_SYS);
         `CHK("ready", u == 0, REQ_READY)
         if (u == 1) `CHK("acq", acq_word, ACQ_DATA)
         `CHK("acq_valid", u == 1, ACQ_VALID)
      end
      DATA_USE = PIN_EXTERNAL_MEMORY_MODE;
      ACQ_ENABLE = 1'b0;
      acq_word = 32'hFFFFFFFF;
      FLAG2_USE = FLG_ALT;
      FLAG3_USE = FLG_ALT;
      TIMER_EXPIRY_IN = 1'b1;
      FLAG_I = 4'h0;
      repeat (2) @(negedge CLK_SYS);
      `CHK("irq2", 1'b1, IRQ2_REQ)
      `CHK("timer_out", 1'b1, FLAG_O[3])
      `CHK("alt_oe", 2'h2, FLAG_OE[3:2])
      `CHK("flag_in", 4'h0, FLAG_IN_Q)
      FLAG2_USE = FLG_BANK;
      FLAG3_USE = FLG_BANK;
      repeat (2) @(negedge CLK_SYS);
      `CHK("pullup", 2'h3, FLAG_PULLUP[3:2])
      `CHK("bank_oe", 2'h3, FLAG_OE[3:2])
      `CHK("bank_idle", 2'h3, FLAG_O[3:2])
      // Banks two and three reach the flag pins only in select use
      for (int b = 2; b < 4; b++) begin
         adr[b] = {2'(b), adr[b][21:0]};
         access(1'b1, adr[b]);
         access(1'b0, adr[b]);
      end
      access(1'b0, adr[0]);
      for (int i = 0; i < 100 && q.size() != 0; i++) @(negedge CLK_SYS);
      `CHK("drain", 1'b1, q.size() == 0)
      close_out();
   end
endmodule : external_async_memory_port_test
